// ---- design/clock_select_regs.vh ----
// Purpose: offsets, fields, reset values and timing counts of the clock selector
// Assumes: 32-bit AHB-Lite words; register index times four is the byte address
// Notes:   definitions only
`ifndef CLOCK_SELECT_REGS_VH
`define CLOCK_SELECT_REGS_VH

// ==========================================================================
// register indexes (byte address is index times four)
`define IDX_SOURCE_CONTROL      12'hF86
`define IDX_SECONDARY_CONTROL   12'hF87

// ==========================================================================
// clock_source_control fields, reset values of both registers and the secondary write mask
`define BIT_PRECISION_EN        7
`define BIT_CRYSTAL_EN          6
`define BIT_BACKUP_EN           5
`define BIT_PRIMARY_FAIL_EN     4
`define BIT_BACKUP_FAIL_EN      3
`define SEL_HI                  2
`define SEL_LO                  0
`define RST_SOURCE_CONTROL      8'hA0
`define RST_SECONDARY_CONTROL   8'h20
`define SECONDARY_WMASK         8'hC7

// ==========================================================================
// source select codes
`define SEL_PRECISION           3'h0
`define SEL_CRYSTAL             3'h2
`define SEL_BACKUP              3'h3
`define SEL_EXTERNAL            3'h4

// ==========================================================================
// unlock key values
`define KEY_FIRST               8'hE7
`define KEY_SECOND              8'h18

// ==========================================================================
// timing
`define BACKUP_FAIL_CYCLES      8004
`define BACKUP_OSC_HZ           10000
`define PRIMARY_FAIL_HZ         1000
`define PRIMARY_FAIL_TICKS      (`BACKUP_OSC_HZ / `PRIMARY_FAIL_HZ)

`endif

// ---- design/unlock_sequencer.v ----
// Purpose: two-key unlock tracker shared by both clock control registers
// Assumes: wr_strobe is a one-cycle pulse per accepted register write
// Notes:   commit pulses on the write that follows a full key sequence
`timescale 1ns/1ps
`include "clock_select_regs.vh"

module unlock_sequencer (
    input  wire       hclk,
    input  wire       hresetn,
    input  wire       wr_strobe,
    input  wire [7:0] wr_value,
    output wire       commit,
    output wire       unlocked
);
    localparam [1:0] LOCKED  = 2'h0;
    localparam [1:0] GOT_ONE = 2'h1;
    localparam [1:0] OPEN    = 2'h2;

    reg [1:0] state;
    reg [1:0] next_state;

    // ======================================================================
    // next key state; other values leave progress alone
    always @* begin
        next_state = state;
        if (wr_strobe) begin
            case (state)
                LOCKED: begin
                    if (wr_value == `KEY_FIRST)
                        next_state = GOT_ONE;
                end
                GOT_ONE: begin
                    if (wr_value == `KEY_SECOND)
                        next_state = OPEN;
                end
                OPEN: begin
                    next_state = LOCKED;
                end
                default: begin
                    next_state = LOCKED;
                end
            endcase
        end
    end

    // ======================================================================
    // reset always drops any partial progress
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            state <= LOCKED;
        else
            state <= next_state;
    end

    assign commit   = wr_strobe && (state == OPEN);
    assign unlocked = (state == OPEN);
endmodule

// ---- design/edge_timeout.v ----
// Purpose: declares a failure when no edge arrives within a count of ticks
// Assumes: edge_seen and tick are synchronous to hclk; tick held high counts each cycle
// Notes:   fail pulses once; the count holds until an edge or disable
`timescale 1ns/1ps

module edge_timeout #(
    parameter WIDTH = 14,
    parameter LIMIT = 8004
) (
    input  wire       hclk,
    input  wire       hresetn,
    input  wire       enable,
    input  wire       tick,
    input  wire       edge_seen,
    output reg        fail
);
    reg [WIDTH-1:0] count;
    wire            at_limit = (count == LIMIT[WIDTH-1:0]);

    // ======================================================================
    // count ticks since the last edge; saturate at the limit
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= {WIDTH{1'b0}};
            fail  <= 1'b0;
        end else begin
            fail <= 1'b0;
            if (!enable || edge_seen) begin
                count <= {WIDTH{1'b0}};
            end else if (tick && !at_limit) begin
                count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
                if (count == LIMIT[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1})
                    fail <= 1'b1;
            end
        end
    end
endmodule

// ---- design/system_clock_select_fail_monitor.v ----
// Purpose: system clock source select with key unlock and oscillator fail monitors
//          for the system clock tree
// Assumes: hclk free-running; oscillator activity arrives as asynchronous pins
//          backup pin toggles near ten kilohertz
// Notes:   zero-wait AHB-Lite slave, OKAY always, unmapped reads return zero
//          fallback wins over a same-cycle software select
// How it works
// - writes need E7h then 18h unlock first
// - next write commits, then relocks at once
// - out-of-order write sequences change nothing
// - keys ordered, other values between allowed
// - other register traffic leaves unlock state alone
// - precision oscillator enable set at reset, software-cleared
// - primary failure raises event, falls back to backup
// - fallback only if backup enabled, not selected
// - primary fails below about one kilohertz
// - backup failure raises event, keeps source
// - after backup failure primary detection stops
// - backup fails after 8004 cycles without edge
// - selected source and both detectors off: device stops
// - select codes 000, 010, 011, 100 only
// - two detector enables, both cleared at reset
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "clock_select_regs.vh"

module system_clock_select_fail_monitor #(
    parameter BACKUP_FAIL_CYCLES = `BACKUP_FAIL_CYCLES,
    parameter PRIMARY_FAIL_TICKS = `PRIMARY_FAIL_TICKS
) (
    // clock and power-on reset
    input  wire        hclk,
    input  wire        hresetn,

    // bus slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,

    // oscillator pins
    input  wire        primary_osc_activity,
    input  wire        backup_osc_activity,

    // clock tree controls
    output reg  [2:0]  sysclk_source_select,
    output reg         precision_osc_enable,
    output reg         crystal_osc_enable,
    output reg         backup_osc_enable,

    // events and sticky status
    output reg         primary_fail_event,
    output reg         backup_fail_event,
    output reg         backup_osc_failed,
    output reg         clock_stopped
);
    // ======================================================================
    // register state
    // detector enables
    reg        primary_fail_detect_en;
    reg        backup_osc_fail_detect_en;

    // secondary image, reserved bits masked
    reg  [7:0] secondary_clock_control;

    // data phase flags
    reg        dp_write;
    reg        dp_source;
    reg        dp_secondary;

    // fail counter widths
    localparam BACKUP_WIDTH  = 14;
    localparam PRIMARY_WIDTH = 8;

    // ======================================================================
    // pin synchronisers and edge detection
    // the edge taps sit after two flops
    reg [2:0] primary_sync;
    reg [2:0] backup_sync;
    wire      primary_edge = primary_sync[2] ^ primary_sync[1];
    wire      backup_edge  = backup_sync[2] ^ backup_sync[1];

    // two flops before use; the third only feeds the edge compare
    // a pin resting high gives one edge after reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            primary_sync <= 3'h0;
            backup_sync  <= 3'h0;
        end else begin
            primary_sync <= {primary_sync[1:0], primary_osc_activity};
            backup_sync  <= {backup_sync[1:0], backup_osc_activity};
        end
    end

    // ======================================================================
    // address decode; index is the word address
    // upper bits must be zero, so no aliases
    function is_index;
        input [31:0] addr;
        input [11:0] idx;
        begin
            is_index = (addr[13:2] == idx) && (addr[31:14] == 18'h0);
        end
    endfunction

    // taken only while the bus is ready
    wire addr_phase = hsel && htrans[1] && hready;
    wire hit_source = is_index(haddr, `IDX_SOURCE_CONTROL);
    wire hit_second = is_index(haddr, `IDX_SECONDARY_CONTROL);

    // read image of the source register
    wire [7:0] source_read = {precision_osc_enable, crystal_osc_enable, backup_osc_enable,
                              primary_fail_detect_en, backup_osc_fail_detect_en,
                              sysclk_source_select};

    // capture the address phase; reads are staged into hrdata here
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write     <= 1'b0;
            dp_source    <= 1'b0;
            dp_secondary <= 1'b0;
            hrdata       <= 32'h0;

            hreadyout    <= 1'b0;
            hresp        <= 1'b0;
        end else begin
            // never a wait state, never an error
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;

            dp_write     <= addr_phase && hwrite;
            dp_source    <= addr_phase && hit_source;
            dp_secondary <= addr_phase && hit_second;

            // zero wait: data ready for the data phase
            if (addr_phase && !hwrite) begin
                if (hit_source)
                    hrdata <= {24'h0, source_read};
                else if (hit_second)
                    hrdata <= {24'h0, secondary_clock_control};
                else
                    hrdata <= 32'h0;
            end
        end
    end

    // ======================================================================
    // unlock tracker; only writes to the two control registers feed it
    // reads and other addresses never reach it
    wire wr_ctrl = dp_write && (dp_source || dp_secondary);
    wire commit;

    // one tracker serves both registers

    unlock_sequencer u_unlock (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .wr_strobe (wr_ctrl),
        .wr_value  (hwdata[7:0]),
        .commit    (commit),
        .unlocked  ()
    );

    // reserved select codes are refused; the field keeps its value
    // a reserved code would select no clock at all
    function sel_legal;
        input [2:0] code;
        begin
            sel_legal = (code == `SEL_PRECISION) || (code == `SEL_CRYSTAL) ||
                        (code == `SEL_BACKUP) || (code == `SEL_EXTERNAL);
        end
    endfunction

    // ======================================================================
    // failure monitors
    wire backup_fail_pulse;
    wire primary_fail_pulse;

    // backup detection stops once it has fired
    wire backup_mon_en  = backup_osc_fail_detect_en && !backup_osc_failed;
    // primary detection needs a live backup reference
    wire primary_mon_en = primary_fail_detect_en && !backup_osc_failed;

    // slow system clocks make this detection slow
    // count every system clock while waiting for a backup edge
    edge_timeout #(
        .WIDTH (BACKUP_WIDTH),
        .LIMIT (BACKUP_FAIL_CYCLES)
    ) u_backup_mon (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .enable    (backup_mon_en),
        .tick      (1'b1),
        .edge_seen (backup_edge),
        .fail      (backup_fail_pulse)
    );

    // backup ticks at ten kilohertz; ten with no primary edge is below one kilohertz
    // no margin: the limit is exactly ten backup ticks, whatever the backup spread
    edge_timeout #(
        .WIDTH (PRIMARY_WIDTH),
        .LIMIT (PRIMARY_FAIL_TICKS)
    ) u_primary_mon (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .enable    (primary_mon_en),
        .tick      (backup_edge),
        .edge_seen (primary_edge),
        .fail      (primary_fail_pulse)
    );

    // backup must run and not already drive the clock
    wire fallback_ok = backup_osc_enable &&
                       (sysclk_source_select != `SEL_BACKUP);

    // ======================================================================
    // control register updates, fallback and fail events
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            precision_osc_enable      <= 1'b1;
            crystal_osc_enable        <= 1'b0;
            backup_osc_enable         <= 1'b1;
            primary_fail_detect_en    <= 1'b0;
            backup_osc_fail_detect_en <= 1'b0;

            sysclk_source_select      <= `SEL_PRECISION;
            secondary_clock_control   <= `RST_SECONDARY_CONTROL;

            primary_fail_event        <= 1'b0;
            backup_fail_event         <= 1'b0;
            backup_osc_failed         <= 1'b0;
        end else begin
            // events fall back by default
            primary_fail_event <= 1'b0;
            backup_fail_event  <= 1'b0;

            if (commit && dp_source) begin
                // only a committed write touches the enable; no auto clear
                precision_osc_enable      <= hwdata[`BIT_PRECISION_EN];
                crystal_osc_enable        <= hwdata[`BIT_CRYSTAL_EN];
                backup_osc_enable         <= hwdata[`BIT_BACKUP_EN];
                primary_fail_detect_en    <= hwdata[`BIT_PRIMARY_FAIL_EN];
                backup_osc_fail_detect_en <= hwdata[`BIT_BACKUP_FAIL_EN];
                // a reserved code leaves the source alone
                if (sel_legal(hwdata[`SEL_HI:`SEL_LO]))
                    sysclk_source_select <= hwdata[`SEL_HI:`SEL_LO];
            end

            // reserved bits read back clear after a committed write; reset sets bit 5
            if (commit && dp_secondary)
                secondary_clock_control <= hwdata[7:0] & `SECONDARY_WMASK;

            // fallback wins over a same-cycle software select
            if (primary_fail_pulse) begin
                primary_fail_event <= 1'b1;
                if (fallback_ok)
                    sysclk_source_select <= `SEL_BACKUP;
            end

            // no source change on backup failure
            if (backup_fail_pulse) begin
                backup_fail_event <= 1'b1;
                backup_osc_failed <= 1'b1;
            end
        end
    end

    // ======================================================================
    // stopped: selected source off and nothing left to recover
    reg src_on;
    wire all_off;

    // the external pin has no enable, so it counts as running
    always @* begin
        case (sysclk_source_select)
            `SEL_PRECISION: src_on = precision_osc_enable;
            `SEL_CRYSTAL:   src_on = crystal_osc_enable;
            `SEL_BACKUP:    src_on = backup_osc_enable;
            default:        src_on = 1'b1;
        endcase
    end

    // selected source not running and no detector left to raise the alarm
    assign all_off = !src_on && !primary_fail_detect_en && !backup_osc_fail_detect_en;

    // status only; it gates no clock itself
    // latched until power-on reset; nothing else can restart the clock
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            clock_stopped <= 1'b0;
        else if (all_off)
            clock_stopped <= 1'b1;
    end
endmodule

// ---- test/clock_select_checker.sv ----
// Purpose: port-level checks of the clock selector
// Assumes: one hclk domain; bound onto the top module
// Notes:   unlock ordering is left to the bench, it needs register reads
`timescale 1ns/1ps
module clock_select_checker #(
    parameter BACKUP_FAIL_CYCLES = 8004,
    parameter PRIMARY_FAIL_TICKS = 10
) (
    input wire        hclk,
    input wire        hresetn,
    input wire [31:0] hwdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        backup_osc_activity,
    input wire [2:0]  sysclk_source_select,
    input wire        precision_osc_enable,
    input wire        backup_osc_enable,
    input wire        primary_fail_event,
    input wire        backup_fail_event,
    input wire        backup_osc_failed,
    input wire        clock_stopped
);
    // ==========================================================
    // cycles since the backup pin last moved; saturates so it never wraps
    reg [15:0] quiet;
    reg        last_pin;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet    <= 16'h0000;
            last_pin <= 1'b0;
        end else begin
            last_pin <= backup_osc_activity;
            if (backup_osc_activity != last_pin)
                quiet <= 16'h0000;
            else if (quiet != 16'hFFFF)
                quiet <= quiet + 16'h0001;
        end
    end

    // ==========================================================
    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence primary_trip;
        primary_fail_event && backup_osc_enable;
    endsequence
    sequence primary_blocked;
        primary_fail_event && !backup_osc_enable;
    endsequence

    a_resp_okay:
        assert property (hresp == 1'b0) else $error("bus response not okay");
    a_zero_wait:
        assert property ($past(hresetn) |-> hreadyout) else $error("wait state seen");
    a_select_legal:
        assert property (sysclk_source_select inside {3'h0, 3'h2, 3'h3, 3'h4})
        else $error("reserved select code");
    a_fallback_taken:
        assert property (primary_trip |-> sysclk_source_select == 3'h3)
        else $error("no fallback to backup");
    a_fallback_needs_en:
        assert property (primary_blocked |-> $stable(sysclk_source_select))
        else $error("fallback without backup");
    a_event_pulse:
        assert property (primary_fail_event |=> !primary_fail_event)
        else $error("primary event too long");
    a_backup_keeps_sel:
        assert property (backup_fail_event |-> $stable(sysclk_source_select) ##[0:1] backup_osc_failed)
        else $error("backup fail misbehaves");
    a_failed_sticky:
        assert property ($past(backup_osc_failed) |-> backup_osc_failed) else $error("flag dropped");
    a_primary_blind:
        assert property ($past(backup_osc_failed) |-> !primary_fail_event)
        else $error("primary event after backup fail");
    a_backup_timeout:
        assert property (backup_fail_event |-> quiet >= BACKUP_FAIL_CYCLES - 1)
        else $error("backup fail too early");
    a_stop_sticky:
        assert property ($past(clock_stopped) |-> clock_stopped) else $error("stop flag dropped");
    a_precision_kept:
        assert property ($fell(precision_osc_enable) |-> !$past(hwdata[7]))
        else $error("precision enable cleared by itself");
endmodule

bind system_clock_select_fail_monitor clock_select_checker #(
    .BACKUP_FAIL_CYCLES(BACKUP_FAIL_CYCLES),
    .PRIMARY_FAIL_TICKS(PRIMARY_FAIL_TICKS)
) u_clock_select_checker (
    .hclk(hclk), .hresetn(hresetn), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .backup_osc_activity(backup_osc_activity),
    .sysclk_source_select(sysclk_source_select), .precision_osc_enable(precision_osc_enable),
    .backup_osc_enable(backup_osc_enable), .primary_fail_event(primary_fail_event),
    .backup_fail_event(backup_fail_event), .backup_osc_failed(backup_osc_failed),
    .clock_stopped(clock_stopped)
);

// ---- test/osc_pin_model.sv ----
// Purpose: oscillator pins seen by the clock selector
// Assumes: primary toggles each hclk, backup every four while enabled
// Notes:   a halted oscillator freezes its pin, as a dead clock would
`timescale 1ns/1ps
module osc_pin_model (
    input  wire hclk,
    input  wire primary_halt,
    input  wire backup_halt,
    input  wire backup_osc_enable,
    output reg  primary_osc_activity,
    output reg  backup_osc_activity
);
    reg [1:0] div;
    initial begin
        div = 2'h0;
        primary_osc_activity = 1'b0;
        backup_osc_activity = 1'b0;
    end
    // ==========================================================
    // primary is taken as stable and pin-configured at once
    // backup only runs while enabled, so it is started before use
    always @(posedge hclk) begin
        div <= div + 2'h1;
        if (!primary_halt)
            primary_osc_activity <= ~primary_osc_activity;
        if (div == 2'h3 && backup_osc_enable && !backup_halt)
            backup_osc_activity <= ~backup_osc_activity;
    end
endmodule

// ---- test/test_system_clock_select_fail_monitor.sv ----
// Purpose: self-checking bench for the clock selector
// Assumes: shortened fail counts; zero-wait bus slave
// Notes:   unlock order, select codes, fallback and fail timing
`timescale 1ns/1ps
`include "clock_select_regs.vh"
module test_system_clock_select_fail_monitor;
    localparam int BFC = 20;
    localparam int PFT = 3;
    localparam logic [31:0] CTL = {18'h00000, `IDX_SOURCE_CONTROL, 2'b00};
    localparam logic [31:0] SEC = {18'h00000, `IDX_SECONDARY_CONTROL, 2'b00};
    reg        hclk, hresetn, hwrite, primary_halt, backup_halt, backup_run;
    reg [1:0]  htrans;
    reg [31:0] haddr, hwdata, rd;
    reg [2:0]  exp_sel;
    wire [31:0] hrdata;
    wire [2:0]  sysclk_source_select;
    wire        hreadyout, hresp, primary_osc_activity, backup_osc_activity;
    wire        precision_osc_enable, crystal_osc_enable, backup_osc_enable;
    wire        primary_fail_event, backup_fail_event, backup_osc_failed, clock_stopped;
    int         failures, check_count, n;

    system_clock_select_fail_monitor #(.BACKUP_FAIL_CYCLES(BFC), .PRIMARY_FAIL_TICKS(PFT))
    u_system_clock_select_fail_monitor (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .primary_osc_activity(primary_osc_activity), .backup_osc_activity(backup_osc_activity),
        .sysclk_source_select(sysclk_source_select), .precision_osc_enable(precision_osc_enable),
        .crystal_osc_enable(crystal_osc_enable), .backup_osc_enable(backup_osc_enable),
        .primary_fail_event(primary_fail_event), .backup_fail_event(backup_fail_event),
        .backup_osc_failed(backup_osc_failed), .clock_stopped(clock_stopped));
    osc_pin_model u_osc_pin_model (
        .hclk(hclk), .primary_halt(primary_halt), .backup_halt(backup_halt),
        .backup_osc_enable(backup_osc_enable | backup_run),
        .primary_osc_activity(primary_osc_activity),
        .backup_osc_activity(backup_osc_activity));

    // ==========================================================
    always #25 hclk = ~hclk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one single transfer; hrdata is taken at the edge that ends the data phase
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [31:0] a, input logic [31:0] exp, input string what);
        xfer(a, 1'b0, 32'h00000000);
        chk(what, exp, rd);
    endtask
    task automatic uw(input logic [31:0] a, input logic [31:0] v);
        xfer(a, 1'b1, 32'h000000E7);
        xfer(a, 1'b1, 32'h00000018);
        xfer(a, 1'b1, v);
    endtask
    // events stand one cycle, so look after every edge under a bound
    task automatic wait_ev(input bit backup, input int lim);
        n = 0;
        while ((backup ? backup_fail_event : primary_fail_event) !== 1'b1 && n < lim) begin
            @(posedge hclk);
            n++;
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================================
    initial begin
        {hclk, hresetn, hwrite, primary_halt, backup_halt, backup_run} = 6'h00;
        htrans = 2'b00;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        failures = 0;
        check_count = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(CTL, 32'h000000A0, "ctl reset");
        rchk(SEC, 32'h00000020, "sec reset");
        $display("test reset done");
        xfer(CTL, 1'b1, 32'h00000083);
        xfer(CTL, 1'b1, 32'h00000018);
        xfer(CTL, 1'b1, 32'h000000E7);
        xfer(CTL, 1'b1, 32'h00000083);
        rchk(CTL, 32'h000000A0, "ctl locked");
        xfer(32'h00000100, 1'b1, 32'h000000FF);
        rchk(32'h00000100, 32'h00000000, "unmapped");
        xfer(CTL, 1'b1, 32'h00000018);
        xfer(CTL, 1'b1, 32'h000000E2);
        rchk(CTL, 32'h000000E2, "ctl commit");
        xfer(CTL, 1'b1, 32'h000000A0);
        rchk(CTL, 32'h000000E2, "ctl relocked");
        uw(SEC, 32'h000000FF);
        rchk(SEC, 32'h000000C7, "sec commit");
        $display("test unlock done");
        // every select code; reserved ones keep the previous source
        exp_sel = 3'h2;
        for (int c = 0; c < 8; c++) begin
            uw(CTL, 32'hE0 | c);
            if (c == 0 || (c >= 2 && c <= 4))
                exp_sel = c[2:0];
            rchk(CTL, {24'h000000, 5'h1C, exp_sel}, "select");
        end
        $display("test codes done");
        uw(CTL, 32'h000000E2);
        uw(CTL, 32'h000000F2);
        primary_halt <= 1'b1;
        wait_ev(1'b0, 100);
        chk("primary delay", 1, n >= (PFT - 1) * 4 && n <= (PFT + 2) * 8);
        chk("fallback select", 3, sysclk_source_select);
        primary_halt <= 1'b0;
        // backup reference kept alive by its other user while its enable reads low
        backup_run <= 1'b1;
        uw(CTL, 32'h000000E2);
        uw(CTL, 32'h000000D2);
        primary_halt <= 1'b1;
        wait_ev(1'b0, 100);
        chk("blocked event", 1, n < 100);
        chk("no fallback", 2, sysclk_source_select);
        {primary_halt, backup_run} <= 2'h0;
        $display("test primary done");
        uw(CTL, 32'h000000EA);
        repeat (8) @(posedge hclk);
        backup_halt <= 1'b1;
        wait_ev(1'b1, 200);
        chk("backup delay", 1, n >= BFC - 8 && n <= BFC + 12);
        chk("backup keeps select", 2, sysclk_source_select);
        backup_halt <= 1'b0;
        uw(CTL, 32'h000000F2);
        chk("failed flag", 1, backup_osc_failed);
        primary_halt <= 1'b1;
        wait_ev(1'b0, 80);
        chk("primary blind", 0, primary_fail_event);
        primary_halt <= 1'b0;
        $display("test backup done");
        uw(CTL, 32'h00000002);
        rchk(CTL, 32'h00000002, "all off");
        chk("stopped", 1, clock_stopped);
        xfer(CTL, 1'b1, 32'h000000E7);
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(CTL, 1'b1, 32'h00000018);
        xfer(CTL, 1'b1, 32'h00000083);
        rchk(CTL, 32'h000000A0, "relock on reset");
        chk("stop cleared", 0, clock_stopped);
        $display("test reset rerun done");
        tally_and_finish();
    end

    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge hclk);
        failures++;
        tally_and_finish();
    end
endmodule
